// *** hw/bus_matching_fifo_ports.sv ***
// One-directional 36-bit FIFO from port A to port B with bus matching on port B.
// Assumes port A is clocked by sys_clk_in, port B by its own free-running clock,
// and that the select and enable pins of each port are synchronous to its clock.
// It also assumes the offset and configuration pins stay static while the FIFO runs.
//
// Operation
// R1 - Port A has a 36-bit two-way data bus for the writer.
// R2 - Port B has a 36-bit two-way data bus for the reader.
// R3 - Almost-empty goes low on port B clock when stored words reach the empty threshold.
// R4 - Almost-full goes low on port A clock when free places reach the full threshold.
// R5 - Select high during reset picks big-endian: most significant piece read first.
// R6 - Select low during reset picks little-endian: least significant piece read first.
// R7 - After reset the select pin picks timing: high standard, low fall-through.
// R8 - The controller holds the endian/timing select steady while the device runs.
// R9 - Bus match low gives 36-bit port B; high gives word or byte by size.
// R10 - The controller holds bus match steady while the device runs.
// R11 - Port A transfers and its full and almost-full flags move on port A rising edges.
// R12 - Port B transfers and its empty and almost-empty flags move on port B rising edges.
// R13 - Works with port clocks asynchronous or coincident.
// R14 - Port A transfers only while its chip select is low.
// R15 - Port A data outputs float while its chip select is high.
// R16 - Port B transfers only while its chip select is low.
// R17 - Port B data outputs float while its chip select is high.
// R18 - Port A transfers only while its enable is high.
// R19 - Port B transfers only while its enable is high.
// R20 - Output flag shows valid output data in fall-through, not-empty in standard.
// R21 - Input flag shows free space in fall-through, not-full in standard.
// R22 - Reset leaves the FIFO empty, almost-empty low, almost-full high, no valid output.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_regs.svh"

module bus_matching_fifo_ports #(
    parameter int DEPTH      = `FIFO_DEPTH,
    parameter int ADDR_WIDTH = $clog2(DEPTH),
    parameter int PTR_WIDTH  = ADDR_WIDTH + 1
) (
    // Port A clock and reset.
    input  wire logic                        sys_clk_in,
    input  wire logic                        reset_in,
    // Port B clock.
    input  wire logic                        port_b_clock_in,
    // Port A pins.
    input  wire logic [`FIFO_DATA_WIDTH-1:0] port_a_data_in,
    output logic      [`FIFO_DATA_WIDTH-1:0] port_a_data_out,
    output logic                             port_a_data_oe_out,
    input  wire logic                        port_a_select_n_in,
    input  wire logic                        port_a_enable_in,
    output logic                             full_or_input_space_out,
    output logic                             almost_full_flag_n_out,
    // Port B pins.
    input  wire logic [`FIFO_DATA_WIDTH-1:0] port_b_data_in,
    output logic      [`FIFO_DATA_WIDTH-1:0] port_b_data_out,
    output logic                             port_b_data_oe_out,
    input  wire logic                        port_b_select_n_in,
    input  wire logic                        port_b_enable_in,
    output logic                             empty_or_output_valid_out,
    output logic                             almost_empty_flag_n_out,
    // Configuration pins.
    input  wire logic                        endian_timing_select_in,
    input  wire logic                        bus_width_match_select_in,
    input  wire logic                        port_b_size_select_in,
    input  wire logic [PTR_WIDTH-1:0]        almost_empty_offset_in,
    input  wire logic [PTR_WIDTH-1:0]        almost_full_offset_in
);

    function automatic logic [PTR_WIDTH-1:0] to_gray(input logic [PTR_WIDTH-1:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [PTR_WIDTH-1:0] from_gray(input logic [PTR_WIDTH-1:0] g);
        logic [PTR_WIDTH-1:0] b;
        b[PTR_WIDTH-1] = g[PTR_WIDTH-1];
        for (int i = PTR_WIDTH - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : from_gray

    // Picks one piece of a stored word for the port B bus; narrow pieces sit low.
    function automatic logic [`FIFO_DATA_WIDTH-1:0] piece_of(
        input logic [`FIFO_DATA_WIDTH-1:0] word,
        input logic [1:0]                  idx,
        input fifo_port_pkg::bus_width_type width,
        input logic                        big
    );
        logic [1:0] lane;
        lane = 2'h0;
        case (width)
            fifo_port_pkg::WIDTH_WORD: begin
                lane = big ? {1'b0, ~idx[0]} : {1'b0, idx[0]}; // [R5] [R6]
                piece_of = lane[0] ? {18'h0, word[35:18]} : {18'h0, word[17:0]};
            end
            fifo_port_pkg::WIDTH_BYTE: begin
                lane = big ? 2'h3 - idx : idx; // [R5] [R6]
                piece_of = {27'h0, word[int'(lane)*`FIFO_BYTE_WIDTH +: `FIFO_BYTE_WIDTH]};
            end
            default: begin
                piece_of = word;
            end
        endcase
    endfunction : piece_of

    localparam logic [PTR_WIDTH-1:0] DEPTH_COUNT = PTR_WIDTH'(DEPTH);

    // Storage is written on the port A clock and read on the port B clock; the gray
    // pointer crossing keeps a read away from any entry still being written.
    logic [`FIFO_DATA_WIDTH-1:0] mem [DEPTH];
    // Port B read pointer in gray code; the port A synchroniser reads it.
    logic [PTR_WIDTH-1:0]        rptr_gray;

    // ---------------- Port A domain ----------------
    logic [PTR_WIDTH-1:0]        wptr_bin;
    logic [PTR_WIDTH-1:0]        wptr_gray;
    logic [PTR_WIDTH-1:0]        rptr_gray_meta;
    logic [PTR_WIDTH-1:0]        rptr_gray_sync;
    // The almost-full offset pin is static; a change is seen two port A clock edges later.
    logic [PTR_WIDTH-1:0]        af_offset_meta;
    logic [PTR_WIDTH-1:0]        af_offset_sync;
    logic [PTR_WIDTH-1:0]        next_wptr_bin;
    logic [PTR_WIDTH-1:0]        next_wptr_gray;
    logic                        next_space;
    logic                        next_af_n;
    logic                        write_now;
    logic [PTR_WIDTH-1:0]        free_count;

    // Free places count the memory alone: the port B holding word sits outside it, so a
    // FIFO whose first word has fallen through takes DEPTH more writes before it is full.
    // The flags look at the pointer after this edge's write, so they move on that edge.
    always_comb begin
        // Write only with select low, enable high and room reported. [R14] [R18] [R11]
        write_now      = !port_a_select_n_in && port_a_enable_in && full_or_input_space_out;
        next_wptr_bin  = wptr_bin + PTR_WIDTH'(write_now);
        next_wptr_gray = to_gray(next_wptr_bin);
        free_count     = DEPTH_COUNT - (next_wptr_bin - from_gray(rptr_gray_sync));
        next_space     = (free_count != '0); // [R21]
        next_af_n      = !(free_count <= af_offset_sync); // [R4]
        // Reset wins over a write presented in the same cycle.
        if (reset_in) begin
            next_wptr_bin  = '0; // [R22]
            next_wptr_gray = '0;
            next_space     = `FIFO_SPACE_RESET;
            next_af_n      = `FIFO_AF_N_RESET;
        end
    end

    // The read pointer and the almost-full offset pass two flip-flops before use.
    always_ff @(posedge sys_clk_in) begin
        rptr_gray_meta <= rptr_gray;
        rptr_gray_sync <= rptr_gray_meta; // [R13]
        af_offset_meta <= almost_full_offset_in;
        af_offset_sync <= af_offset_meta;
    end

    // Write pointer, flags and storage of the port A domain.
    always_ff @(posedge sys_clk_in) begin
        wptr_bin                <= next_wptr_bin;
        wptr_gray               <= next_wptr_gray;
        full_or_input_space_out <= next_space; // [R11]
        almost_full_flag_n_out  <= next_af_n;
        // Port A has nothing to read in this block, so its bus never drives. [R1] [R15]
        port_a_data_out         <= '0;
        port_a_data_oe_out      <= 1'b0;
        if (write_now) begin
            mem[wptr_bin[ADDR_WIDTH-1:0]] <= port_a_data_in; // [R1]
        end
    end

    // ---------------- Port B domain ----------------
    // Master reset reaches this domain through two flip-flops, so port B keeps its reset
    // values for two port B edges after reset_in falls. The endian choice is the select as
    // seen through the same two flip-flops, so it is the level held during reset.
    logic                        reset_b_meta;
    logic                        reset_b;
    logic [PTR_WIDTH-1:0]        wptr_gray_meta;
    logic [PTR_WIDTH-1:0]        wptr_gray_sync;
    logic                        select_meta;
    logic                        select_sync;
    logic                        match_meta;
    logic                        match_sync;
    logic                        size_meta;
    logic                        size_sync;
    // Bus width, size and almost-empty offset pins are static; they settle two port B edges after a change.
    logic [PTR_WIDTH-1:0]        ae_offset_meta;
    logic [PTR_WIDTH-1:0]        ae_offset_sync;
    logic [PTR_WIDTH-1:0]        rptr_bin;
    logic [`FIFO_DATA_WIDTH-1:0] hold_word;
    logic                        hold_valid;
    logic [1:0]                  piece_idx;
    logic                        big_endian;

    logic [PTR_WIDTH-1:0]        next_rptr_bin;
    logic [PTR_WIDTH-1:0]        next_rptr_gray;
    logic [`FIFO_DATA_WIDTH-1:0] next_hold_word;
    logic                        next_hold_valid;
    logic [1:0]                  next_piece_idx;
    logic                        next_big_endian;
    logic [`FIFO_DATA_WIDTH-1:0] next_b_data;
    logic                        next_b_oe;
    logic                        next_ae_n;
    logic                        read_now;
    logic                        mem_empty;
    logic [1:0]                  last_piece;
    logic [PTR_WIDTH-1:0]        word_count;
    fifo_port_pkg::bus_width_type   width_mode;
    fifo_port_pkg::timing_mode_type timing_mode;

    always_comb begin
        // Outside reset the synchronised select names the timing mode; in reset, the endian.
        timing_mode = fifo_port_pkg::timing_mode_type'(select_sync); // [R7]
        if (!match_sync) begin
            width_mode = fifo_port_pkg::WIDTH_LONG; // [R9]
            last_piece = `FIFO_LAST_PIECE_LONG;
        end else if (size_sync) begin
            width_mode = fifo_port_pkg::WIDTH_BYTE;
            last_piece = `FIFO_LAST_PIECE_BYTE;
        end else begin
            width_mode = fifo_port_pkg::WIDTH_WORD;
            last_piece = `FIFO_LAST_PIECE_WORD;
        end
        // Memory is empty once the reads have caught up with the synchronised write pointer.
        mem_empty = (rptr_gray == wptr_gray_sync);
        // Read only with select low, enable high and data reported. [R16] [R19] [R12]
        read_now        = !port_b_select_n_in && port_b_enable_in && empty_or_output_valid_out;
        next_rptr_bin   = rptr_bin;
        next_hold_word  = hold_word;
        next_hold_valid = hold_valid;
        next_piece_idx  = piece_idx;
        next_big_endian = big_endian;
        // A take of the last piece of a word empties the holding word.
        if (read_now) begin
            if (piece_idx >= last_piece) begin
                next_hold_valid = 1'b0;
                next_piece_idx  = 2'h0;
            end else begin
                next_piece_idx = piece_idx + 2'h1;
            end
        end
        // The holding word refills as soon as it empties, so a word falls through.
        if (!next_hold_valid && !mem_empty) begin
            next_hold_word  = mem[rptr_bin[ADDR_WIDTH-1:0]]; // [R2]
            next_hold_valid = 1'b1;
            next_piece_idx  = 2'h0;
            next_rptr_bin   = rptr_bin + 1'b1;
        end
        // Fall-through shows the waiting piece; standard latches it on the read. [R20]
        if (timing_mode == fifo_port_pkg::TIMING_FALL_THROUGH) begin
            next_b_data = piece_of(next_hold_word, next_piece_idx, width_mode, big_endian);
        end else if (read_now) begin
            next_b_data = piece_of(hold_word, piece_idx, width_mode, big_endian);
        end else begin
            next_b_data = port_b_data_out;
        end
        next_b_oe  = !port_b_select_n_in; // [R17]
        // Stored words include the holding word, so almost-empty agrees with the empty flag.
        word_count = from_gray(wptr_gray_sync) - next_rptr_bin + PTR_WIDTH'(next_hold_valid);
        next_ae_n  = !(word_count <= ae_offset_sync); // [R3]
        if (reset_b) begin
            next_big_endian = select_sync; // [R5] [R6]
            next_rptr_bin   = '0; // [R22]
            next_hold_word  = '0;
            next_hold_valid = `FIFO_VALID_RESET;
            next_piece_idx  = 2'h0;
            next_b_data     = '0;
            next_ae_n       = `FIFO_AE_N_RESET;
        end
        next_rptr_gray = to_gray(next_rptr_bin);
    end

    // Reset, the endian/timing, match, size and almost-empty offset pins and the write pointer pass two port B flip-flops before any logic reads them.
    always_ff @(posedge port_b_clock_in) begin
        reset_b_meta   <= reset_in;
        reset_b        <= reset_b_meta;
        wptr_gray_meta <= wptr_gray;
        wptr_gray_sync <= wptr_gray_meta; // [R13]
        select_meta    <= endian_timing_select_in; // [R8]
        select_sync    <= select_meta;
        match_meta     <= bus_width_match_select_in; // [R10]
        match_sync     <= match_meta;
        size_meta      <= port_b_size_select_in;
        size_sync      <= size_meta;
        ae_offset_meta <= almost_empty_offset_in;
        ae_offset_sync <= ae_offset_meta;
    end

    // Read pointer, holding word and port B outputs.
    always_ff @(posedge port_b_clock_in) begin
        rptr_bin                  <= next_rptr_bin;
        rptr_gray                 <= next_rptr_gray;
        hold_word                 <= next_hold_word;
        hold_valid                <= next_hold_valid;
        piece_idx                 <= next_piece_idx;
        big_endian                <= next_big_endian;
        port_b_data_out           <= next_b_data; // [R2]
        port_b_data_oe_out        <= next_b_oe;
        empty_or_output_valid_out <= next_hold_valid; // [R12] [R20]
        almost_empty_flag_n_out   <= next_ae_n;
    end

endmodule : bus_matching_fifo_ports
`default_nettype wire

// *** hw/fifo_port_regs.svh ***
// Constants of the bus-matching FIFO port logic: widths, depth and reset values.
// Assumes inclusion by its bare name from the design file.
`ifndef FIFO_PORT_REGS_SVH
`define FIFO_PORT_REGS_SVH

`define FIFO_DATA_WIDTH     36
`define FIFO_WORD_WIDTH     18
`define FIFO_BYTE_WIDTH     9
`define FIFO_DEPTH          2048
`define FIFO_LAST_PIECE_LONG 2'h0
`define FIFO_LAST_PIECE_WORD 2'h1
`define FIFO_LAST_PIECE_BYTE 2'h3
`define FIFO_SPACE_RESET    1'b1
`define FIFO_AF_N_RESET     1'b1
`define FIFO_VALID_RESET    1'b0
`define FIFO_AE_N_RESET     1'b0

`endif

// *** hw/fifo_port_pkg.sv ***
// Types shared by the bus-matching FIFO port logic.
// Assumes nothing of its surroundings.
package fifo_port_pkg;

    typedef enum logic {
        TIMING_FALL_THROUGH = 1'b0,
        TIMING_STANDARD     = 1'b1
    } timing_mode_type;

    typedef enum logic [1:0] {
        WIDTH_LONG = 2'b00,
        WIDTH_WORD = 2'b01,
        WIDTH_BYTE = 2'b10
    } bus_width_type;

endpackage : fifo_port_pkg

// *** test/fifo_port_checker_assertions.sv ***
// Assertions on the flag, select and output-enable ports of the FIFO port block.
// Assumes binding to bus_matching_fifo_ports; reset_in also masks the port B checks.
`timescale 1ns/1ps
`default_nettype none
module fifo_port_checker (
    // Clocks and reset.
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic port_b_clock_in,
    // Port A.
    input wire logic port_a_select_n_in,
    input wire logic port_a_enable_in,
    input wire logic port_a_data_oe_out,
    input wire logic full_or_input_space_out,
    input wire logic almost_full_flag_n_out,
    // Port B.
    input wire logic port_b_select_n_in,
    input wire logic port_b_enable_in,
    input wire logic port_b_data_oe_out,
    input wire logic empty_or_output_valid_out,
    input wire logic almost_empty_flag_n_out
);
    a_float_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        port_a_select_n_in [*2] |-> !port_a_data_oe_out) else $error("port A bus driven");
    a_full_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (port_a_select_n_in || !port_a_enable_in) |=> !$fell(full_or_input_space_out))
        else $error("full without a write");
    a_afull_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (port_a_select_n_in || !port_a_enable_in) |=> !$fell(almost_full_flag_n_out))
        else $error("almost-full without a write");
    a_full_afull_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !full_or_input_space_out |-> !almost_full_flag_n_out) else $error("full but not almost");
    b_float_a: assert property (@(posedge port_b_clock_in) disable iff (reset_in)
        port_b_select_n_in |=> !port_b_data_oe_out) else $error("port B bus driven");
    b_valid_hold_a: assert property (@(posedge port_b_clock_in) disable iff (reset_in)
        (port_b_select_n_in || !port_b_enable_in) |=> !$fell(empty_or_output_valid_out))
        else $error("valid dropped without a read");
    b_aempty_hold_a: assert property (@(posedge port_b_clock_in) disable iff (reset_in)
        (port_b_select_n_in || !port_b_enable_in) |=> !$fell(almost_empty_flag_n_out))
        else $error("almost-empty without a read");
    b_empty_aempty_a: assert property (@(posedge port_b_clock_in) disable iff (reset_in)
        !empty_or_output_valid_out |-> !almost_empty_flag_n_out) else $error("empty not almost");
endmodule : fifo_port_checker
bind bus_matching_fifo_ports fifo_port_checker u_fifo_port_checker (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .port_b_clock_in(port_b_clock_in),
    .port_a_select_n_in(port_a_select_n_in), .port_a_enable_in(port_a_enable_in),
    .port_a_data_oe_out(port_a_data_oe_out), .full_or_input_space_out(full_or_input_space_out),
    .almost_full_flag_n_out(almost_full_flag_n_out), .port_b_select_n_in(port_b_select_n_in),
    .port_b_enable_in(port_b_enable_in), .port_b_data_oe_out(port_b_data_oe_out),
    .empty_or_output_valid_out(empty_or_output_valid_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out));
`default_nettype wire

// *** test/fifo_reader_model.sv ***
// Port B reader model: selects port B on request, enables every other edge, reports takes.
// Assumes the free-running port B clock and the block's port B data and valid flag.
`timescale 1ns/1ps
`default_nettype none
module fifo_reader_model (
    // Clock and control.
    input  wire logic        clk_in,
    input  wire logic        want_in,
    input  wire logic        standard_in,
    // Block side.
    input  wire logic        valid_in,
    input  wire logic [35:0] data_in,
    output logic             select_n_out,
    output logic             enable_out,
    // Report of each piece taken.
    output logic             got_out,
    output logic [35:0]      got_data_out
);
    logic pending = 1'b0;
    logic stall = 1'b0;
    initial begin
        select_n_out = 1'b1;
        enable_out = 1'b0;
        got_out = 1'b0;
        got_data_out = '0;
    end
    // Standard timing loads the output at the take, so its report waits one edge.
    always @(posedge clk_in) begin
        got_out <= pending;
        got_data_out <= data_in;
        pending <= 1'b0;
        if (!select_n_out && enable_out && valid_in) begin
            pending <= standard_in;
            got_out <= pending || !standard_in;
        end
        stall <= !stall;
        select_n_out <= !want_in;
        enable_out <= want_in && stall;
    end
endmodule : fifo_reader_model
`default_nettype wire

// *** test/test_bus_matching_fifo_ports.sv ***
// Self-checking bench of the FIFO port block: refusals, fill to full, drains, narrow reads.
// Assumes the reader model on port B and the checker bound to the block.
`timescale 1ns/1ps
`default_nettype none
module test_bus_matching_fifo_ports;
    localparam int DEPTH = 16;
    logic sys_clk, reset, b_clk, a_sel_n, a_en, endian_sel, match_sel, size_sel, want, std_mode;
    logic [35:0] a_data;
    logic [35:0] exp_q[$];
    wire logic [35:0] a_q, b_q, got_data;
    wire logic a_oe, b_oe, full_space, afull_n, valid, aempty_n, b_sel_n, b_en, got;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    bus_matching_fifo_ports #(.DEPTH(DEPTH)) u_bus_matching_fifo_ports (
        .sys_clk_in(sys_clk), .reset_in(reset), .port_b_clock_in(b_clk),
        .port_a_data_in(a_data), .port_a_data_out(a_q), .port_a_data_oe_out(a_oe),
        .port_a_select_n_in(a_sel_n), .port_a_enable_in(a_en),
        .full_or_input_space_out(full_space), .almost_full_flag_n_out(afull_n),
        .port_b_data_in(b_oe ? b_q : ~b_q), .port_b_data_out(b_q), .port_b_data_oe_out(b_oe),
        .port_b_select_n_in(b_sel_n), .port_b_enable_in(b_en),
        .empty_or_output_valid_out(valid), .almost_empty_flag_n_out(aempty_n),
        .endian_timing_select_in(endian_sel), .bus_width_match_select_in(match_sel),
        .port_b_size_select_in(size_sel), .almost_empty_offset_in(5'h02),
        .almost_full_offset_in(5'h03));
    fifo_reader_model u_fifo_reader_model (.clk_in(b_clk), .want_in(want),
        .standard_in(std_mode), .valid_in(valid), .data_in(b_q), .select_n_out(b_sel_n),
        .enable_out(b_en), .got_out(got), .got_data_out(got_data));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        b_clk = 1'b0;
        #7;
        forever #80 b_clk = ~b_clk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] expected);
        n_compared++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic test_done;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // The whole run needs about 1100 cycles.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done;
        end
    end
    always @(posedge b_clk) begin
        if (got === 1'b1 && exp_q.size() == 0) check(1'b1, 1'b0);
        else if (got === 1'b1) check(got_data, exp_q.pop_front());
    end
    // Reset must span five port B edges; the select then holds the timing mode steadily.
    task automatic do_reset(input logic big, input logic mode, input logic narrow, input logic size);
        reset <= 1'b1;
        endian_sel <= big;
        match_sel <= narrow;
        size_sel <= size;
        std_mode <= mode;
        repeat (32) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        endian_sel <= mode;
        repeat (24) @(posedge sys_clk);
        @(negedge sys_clk);
        check({full_space, afull_n, valid, aempty_n, a_oe, b_oe}, 6'b110000);
        check(a_q, 36'h0);
        check(b_q, 36'h0);
        @(posedge sys_clk);
    endtask : do_reset
    task automatic drain;
        int k;
        want <= 1'b1;
        repeat (16) @(posedge sys_clk);
        check(b_oe, 1'b1);
        for (k = 0; k < 900 && exp_q.size() > 0; k++) @(posedge sys_clk);
        want <= 1'b0;
        repeat (32) @(posedge sys_clk);
        check(exp_q.size(), 0);
        check({valid, aempty_n, b_oe}, 3'b000);
    endtask : drain
    task automatic test_fill;
        int i;
        logic [35:0] w;
        do_reset(1'b1, 1'b0, 1'b0, 1'b0);
        a_sel_n <= 1'b1;
        a_en <= 1'b1;
        @(posedge sys_clk);
        a_sel_n <= 1'b0;
        a_en <= 1'b0;
        @(posedge sys_clk);
        a_sel_n <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(valid, 1'b0);
        // The first word falls into the port B holding word, leaving all of memory free.
        w = 36'h5_a5a5_a5a5;
        a_data <= w;
        a_sel_n <= 1'b0;
        a_en <= 1'b1;
        exp_q.push_back(w);
        @(posedge sys_clk);
        a_sel_n <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check({valid, aempty_n}, 2'b10);
        check(b_q, w);
        for (i = 0; i <= DEPTH + 1; i++) begin
            w = 36'h9_0000_0000 + 36'(i) * 36'h0_0102_0103;
            a_data <= w;
            a_sel_n <= (i > DEPTH);
            if (i < DEPTH) exp_q.push_back(w);
            @(negedge sys_clk);
            check({full_space, afull_n}, {i < DEPTH, DEPTH - i > 3});
            @(posedge sys_clk);
        end
        repeat (24) @(posedge sys_clk);
        check({valid, aempty_n}, 2'b11);
        drain;
        $display("fill and drain done");
    endtask : test_fill
    task automatic test_narrow(input logic big, input logic mode, input logic size);
        int k;
        int n;
        logic [35:0] w;
        w = 36'hc_3a5e_971b;
        n = size ? 4 : 2;
        do_reset(big, mode, 1'b1, size);
        for (k = 0; k < n; k++) exp_q.push_back((w >> ((big ? n - 1 - k : k) * 36 / n)) & (size ? 36'h1ff : 36'h3ffff));
        a_data <= w;
        a_sel_n <= 1'b0;
        @(posedge sys_clk);
        a_sel_n <= 1'b1;
        drain;
        $display("narrow read done");
    endtask : test_narrow
    initial begin
        reset = 1'b1;
        a_sel_n = 1'b1;
        a_en = 1'b1;
        a_data = '0;
        endian_sel = 1'b1;
        match_sel = 1'b0;
        size_sel = 1'b0;
        want = 1'b0;
        std_mode = 1'b0;
        test_fill;
        test_narrow(1'b1, 1'b1, 1'b0);
        test_narrow(1'b0, 1'b0, 1'b1);
        test_narrow(1'b1, 1'b0, 1'b1);
        test_narrow(1'b0, 1'b1, 1'b0);
        test_done;
    end
endmodule : test_bus_matching_fifo_ports
`default_nettype wire
